/* design/fdma_pkg.sv */
// Constants, register map and configuration layout of the five-channel DMA controller.
// Assumes a single system clock and a byte-wide memory port shared with the CPU.
package fdma_pkg;
	localparam int NCH       = 5;
	localparam int NTRIG     = 32;
	localparam int CFG_BYTES = 8;

	// Register map, byte offsets on the 8-bit register port
	localparam logic [7:0] REG_ARM   = 8'h00;
	localparam logic [7:0] REG_REQ   = 8'h01;
	localparam logic [7:0] REG_IRQ   = 8'h02;
	localparam logic [7:0] REG_CFG0L = 8'h03;
	localparam logic [7:0] REG_CFG0H = 8'h04;
	localparam logic [7:0] REG_CFG1L = 8'h05;
	localparam logic [7:0] REG_CFG1H = 8'h06;
	localparam logic [7:0] REG_READY = 8'h07;
	localparam int ARM_ABORT_BIT = 7;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Configuration structure byte indices
	localparam int CB_SRCH = 0;
	localparam int CB_SRCL = 1;
	localparam int CB_DSTH = 2;
	localparam int CB_DSTL = 3;
	localparam int CB_VARL = 4;
	localparam int CB_LENL = 5;
	localparam int CB_MODE = 6;
	localparam int CB_MISC = 7;
	// Field positions
	localparam int VARL_LSB  = 5;
	localparam int WORD_BIT  = 7;
	localparam int TMODE_LSB = 5;
	localparam int SINC_LSB  = 6;
	localparam int DINC_LSB  = 4;
	localparam int MASK_BIT  = 3;
	localparam int LBW_BIT   = 2;

	// Fetch takes nine clocks: eight reads plus the commit cycle
	localparam int         FETCH_CYCLES = 9;
	localparam logic [3:0] FC_LAST      = 4'(FETCH_CYCLES - 1);
	localparam logic [3:0] FC_LAST_RD   = 4'(FETCH_CYCLES - 2);
	localparam logic [15:0] CFG_STRIDE  = 16'(CFG_BYTES);

	localparam logic [2:0] VL_FIXED = 3'h0;
	localparam logic [2:0] VL_P1    = 3'h1;
	localparam logic [2:0] VL_N     = 3'h2;
	localparam logic [2:0] VL_P2    = 3'h3;
	localparam logic [2:0] VL_P3    = 3'h4;

	localparam logic [1:0] TM_SINGLE  = 2'h0;
	localparam logic [1:0] TM_BLOCK   = 2'h1;
	localparam logic [1:0] TM_RSINGLE = 2'h2;
	localparam logic [1:0] TM_RBLOCK  = 2'h3;

	localparam logic [1:0] INC_NONE = 2'h0;
	localparam logic [1:0] INC_P1   = 2'h1;
	localparam logic [1:0] INC_P2   = 2'h2;
	localparam logic [1:0] INC_M1   = 2'h3;

	localparam logic [1:0] PRI_LOW  = 2'h0;
	localparam logic [1:0] PRI_NORM = 2'h1;
	localparam logic [1:0] PRI_HIGH = 2'h2;

	localparam logic [7:0] PEND_MAX = 8'hff;

	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_RD, S_RW, S_CAP, S_WR} fdma_state_t;
endpackage

/* design/fdma_arb.sv */
// Round-robin channel arbiter, highest priority level first.
// Assumes requests from the same clock; grant is registered one cycle.
`timescale 1ns/1ps
`default_nettype none
module fdma_arb (
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic [fdma_pkg::NCH-1:0]   req,
	input  wire logic [2*fdma_pkg::NCH-1:0] prio,
	input  wire logic                    take,
	input  wire logic [2:0]              take_idx,
	output logic                         gnt_valid,
	output logic [2:0]                   gnt_idx
);
	import fdma_pkg::*;

	logic [2:0] last;
	logic [1:0] best;
	logic [2:0] pick;
	logic       found;

	function automatic logic [1:0] level(input logic [1:0] p);
		// Code 3 behaves as high
		level = (p > PRI_HIGH) ? PRI_HIGH : p;
	endfunction

	always_comb begin
		int j;
		j = 0;
		best = PRI_LOW;
		pick = last;
		found = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			if (req[c] && level(prio[2*c +: 2]) > best) begin
				best = level(prio[2*c +: 2]);
			end
		end
		// Start after the last winner so equal levels take turns
		for (int k = 1; k <= NCH; k++) begin
			j = (int'(last) + k) % NCH;
			if (!found && req[j] && level(prio[2*j +: 2]) == best) begin
				pick = 3'(j);
				found = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			gnt_valid <= 1'b0;
			gnt_idx   <= 3'h0;
		end else begin
			gnt_valid <= found;
			gnt_idx   <= pick;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			last <= 3'(NCH - 1);
		end else if (take) begin
			last <= take_idx;
		end
	end
endmodule
`default_nettype wire

/* design/fdma_ctrl.sv */
// Five-channel DMA controller: register port, configuration fetch and transfer engine.
// Assumes triggers, CPU_REQ and memory read data come from logic on CLK.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Five independent channels, 0 to 4, copy data within data space.
// - A channel runs only after software sets its arm bit.
// - Arming fetches configuration in nine clocks; new-source triggers then are lost.
// - Several armed channels fetch in turn: 1,2,3,4 then 0.
// - Each channel selects one of 32 triggers, known after the fetch.
// - A software request bit starts a transfer regardless of trigger.
// - Old-source triggers during reconfiguration count as missed and start later.
// - Writing the request bit clears missed count and stops fetch-time counting.
// - Request bit clears only when its transfer occurs, not on disarm.
// - After the transfer count the channel rearms or disarms and signals completion.
// - Variable length takes the count from the first source byte or word.
// - A trigger starts one transfer or a whole block, per configuration.
// - Source and destination pointers step independently after each transfer.
// - Single, block, repeated single and repeated block modes.
// - Each transfer moves a byte or a 16-bit word.
// - Completion raises an interrupt request, gated by the channel mask.
// - In byte mode a setting picks seven or eight length bits.
// - Source may be any address of the data space.
// - Three priority levels arbitrate between channels and against the CPU.
// - High beats CPU, normal wins every second try, low yields; ties round-robin.
// - Single and block disarm at completion; repeated forms rearm.
// - Configured length caps variable length; word length uses bits 12:0.
// - Steps are 0, +1, +2 or -1 counts; a count is one or two bytes.
module fdma_ctrl (
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	input  wire logic [fdma_pkg::NTRIG-1:0] TRIG,
	input  wire logic        CPU_REQ,
	output logic      [15:0] MEM_ADDR,
	output logic      [7:0]  MEM_WDATA,
	output logic             MEM_RE,
	output logic             MEM_WE,
	input  wire logic [7:0]  MEM_RDATA,
	output logic      [fdma_pkg::NCH-1:0] IRQ_REQ
);
	import fdma_pkg::*;

	fdma_state_t state;
	logic [NCH-1:0] armed, ready, fetch_pend, swreq, nocount, irq_flag;
	logic [NCH-1:0] arm_set, abort_mask, wr_req, trig_hit, cand;
	logic [7:0]  pend    [NCH];
	logic [7:0]  cfg     [NCH][CFG_BYTES];
	logic [7:0]  stg     [CFG_BYTES];
	logic [15:0] src_ptr [NCH];
	logic [15:0] dst_ptr [NCH];
	logic [12:0] cnt     [NCH];
	logic [12:0] lim     [NCH];
	logic [15:0] cfg0_base, cfg1_base;
	logic [2:0]  act, fdone_ch, done_ch, next_fetch;
	logic [3:0]  fc;
	logic        bidx, lost_last, start_p, fetch_done, fstart, done_p, disarm_p;
	logic [7:0]  dbuf, vlo;
	logic [2*NCH-1:0] prio_flat;
	logic        arb_v;
	logic [2:0]  arb_i;
	logic        ok, is_word, fin, stop;
	logic [13:0] varl_n, vtot, eff_lim, new_cnt;

	function automatic logic [15:0] cfg_addr(input logic [2:0] n, input logic [15:0] b0,
		input logic [15:0] b1);
		// Channels 1..4 sit back to back after the second base
		cfg_addr = (n == 3'h0) ? b0 : 16'(b1 + CFG_STRIDE * 16'(n - 3'h1));
	endfunction

	function automatic logic [15:0] step(input logic [15:0] p, input logic [1:0] inc,
		input logic word);
		logic [15:0] unit;
		unit = word ? 16'h0002 : 16'h0001;
		unique case (inc)
			INC_NONE: step = p;
			INC_P1:   step = 16'(p + unit);
			INC_P2:   step = 16'(p + (unit << 1));
			INC_M1:   step = 16'(p - unit);
		endcase
	endfunction

	function automatic logic may_go(input logic [1:0] p, input logic cpu, input logic lost);
		if (p == PRI_LOW) begin
			may_go = !cpu;
		end else if (p == PRI_NORM) begin
			may_go = !cpu || lost;
		end else begin
			may_go = 1'b1;
		end
	endfunction

	// Register port decode
	always_comb begin
		arm_set    = '0;
		abort_mask = '0;
		wr_req     = '0;
		if (WR && ADDR == REG_ARM) begin
			if (WDATA[ARM_ABORT_BIT]) begin
				abort_mask = WDATA[NCH-1:0];
			end else begin
				arm_set = WDATA[NCH-1:0] & ~armed;
			end
		end
		if (WR && ADDR == REG_REQ) begin
			wr_req = WDATA[NCH-1:0];
		end
	end

	always_comb begin
		next_fetch = 3'h0;
		for (int c = NCH - 1; c >= 1; c--) begin
			if (fetch_pend[c]) begin
				next_fetch = 3'(c);
			end
		end
	end

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			trig_hit[c] = TRIG[cfg[c][CB_MODE][4:0]];
			cand[c] = armed[c] && ready[c] && !abort_mask[c] && (swreq[c] || pend[c] != 8'h00)
				&& !(state != S_IDLE && act == 3'(c));
			prio_flat[2*c +: 2] = cfg[c][CB_MISC][1:0];
		end
	end

	fdma_arb u_arb (
		.clk       (CLK),
		.srst      (SRST),
		.req       (cand),
		.prio      (prio_flat),
		.take      (start_p),
		.take_idx  (act),
		.gnt_valid (arb_v),
		.gnt_idx   (arb_i)
	);

	// Active channel decode and length arithmetic
	always_comb begin
		is_word = cfg[act][CB_MODE][WORD_BIT];
		ok      = may_go(cfg[act][CB_MISC][1:0], CPU_REQ, lost_last);
		stop    = !armed[act] || abort_mask[act];
		fin     = !is_word || bidx;
		if (is_word) begin
			varl_n = {1'b0, dbuf[4:0], vlo};
		end else if (cfg[act][CB_MISC][LBW_BIT]) begin
			varl_n = {6'h00, vlo};
		end else begin
			varl_n = {7'h00, vlo[6:0]};
		end
		unique case (cfg[act][CB_VARL][7:VARL_LSB])
			VL_P1:   vtot = 14'(varl_n + 14'h0001);
			VL_N:    vtot = varl_n;
			VL_P2:   vtot = 14'(varl_n + 14'h0002);
			VL_P3:   vtot = 14'(varl_n + 14'h0003);
			default: vtot = {1'b0, lim[act]};
		endcase
		if (cnt[act] == 13'h0000 && cfg[act][CB_VARL][7:VARL_LSB] != VL_FIXED
			&& vtot < {1'b0, lim[act]}) begin
			eff_lim = vtot;
		end else begin
			eff_lim = {1'b0, lim[act]};
		end
		new_cnt = 14'({1'b0, cnt[act]} + 14'h0001);
	end

	// Configuration fetch and transfer engine
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state      <= S_IDLE;
			MEM_RE     <= 1'b0;
			MEM_WE     <= 1'b0;
			MEM_ADDR   <= RST_WORD;
			MEM_WDATA  <= RST_BYTE;
			act        <= 3'h0;
			fc         <= 4'h0;
			bidx       <= 1'b0;
			dbuf       <= RST_BYTE;
			vlo        <= RST_BYTE;
			lost_last  <= 1'b0;
			start_p    <= 1'b0;
			fstart     <= 1'b0;
			fetch_done <= 1'b0;
			fdone_ch   <= 3'h0;
			done_p     <= 1'b0;
			disarm_p   <= 1'b0;
			done_ch    <= 3'h0;
			for (int c = 0; c < NCH; c++) begin
				src_ptr[c] <= RST_WORD;
				dst_ptr[c] <= RST_WORD;
				cnt[c]     <= '0;
				lim[c]     <= '0;
				for (int b = 0; b < CFG_BYTES; b++) begin
					cfg[c][b] <= RST_BYTE;
				end
			end
			for (int b = 0; b < CFG_BYTES; b++) begin
				stg[b] <= RST_BYTE;
			end
		end else begin
			MEM_RE     <= 1'b0;
			MEM_WE     <= 1'b0;
			start_p    <= 1'b0;
			fstart     <= 1'b0;
			fetch_done <= 1'b0;
			done_p     <= 1'b0;
			disarm_p   <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (|fetch_pend) begin
						act      <= next_fetch;
						fc       <= 4'h0;
						fstart   <= 1'b1;
						MEM_RE   <= 1'b1;
						MEM_ADDR <= cfg_addr(next_fetch, cfg0_base, cfg1_base);
						state    <= S_FETCH;
					end else if (arb_v && cand[arb_i]) begin
						act     <= arb_i;
						start_p <= 1'b1;
						bidx    <= 1'b0;
						state   <= S_RD;
					end
				end
				S_FETCH: begin
					if (fc != 4'h0) begin
						stg[3'(fc - 4'h1)] <= MEM_RDATA;
					end
					if (fc < FC_LAST_RD) begin
						MEM_RE   <= 1'b1;
						MEM_ADDR <= 16'(MEM_ADDR + 16'h0001);
					end
					fc <= 4'(fc + 4'h1);
					if (fc == FC_LAST) begin
						// Old trigger select stays in force until this commit
						for (int b = 0; b < CFG_BYTES - 1; b++) begin
							cfg[act][b] <= stg[b];
						end
						cfg[act][CB_MISC] <= MEM_RDATA;
						src_ptr[act] <= {stg[CB_SRCH], stg[CB_SRCL]};
						dst_ptr[act] <= {stg[CB_DSTH], stg[CB_DSTL]};
						cnt[act]     <= '0;
						lim[act]     <= {stg[CB_VARL][4:0], stg[CB_LENL]};
						fetch_done   <= 1'b1;
						fdone_ch     <= act;
						if (|fetch_pend) begin
							act      <= next_fetch;
							fc       <= 4'h0;
							fstart   <= 1'b1;
							MEM_RE   <= 1'b1;
							MEM_ADDR <= cfg_addr(next_fetch, cfg0_base, cfg1_base);
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_RD: begin
					if (stop) begin
						state <= S_IDLE;
					end else if (ok) begin
						MEM_RE    <= 1'b1;
						MEM_ADDR  <= 16'(src_ptr[act] + 16'(bidx));
						lost_last <= 1'b0;
						state     <= S_RW;
					end else begin
						lost_last <= 1'b1;
					end
				end
				S_RW: begin
					state <= S_CAP;
				end
				S_CAP: begin
					dbuf <= MEM_RDATA;
					if (!bidx) begin
						vlo <= MEM_RDATA;
					end
					state <= S_WR;
				end
				S_WR: begin
					if (stop) begin
						// Abort ends quietly, no completion
						state <= S_IDLE;
					end else if (!ok) begin
						lost_last <= 1'b1;
					end else begin
						MEM_WE    <= 1'b1;
						MEM_ADDR  <= 16'(dst_ptr[act] + 16'(bidx));
						MEM_WDATA <= dbuf;
						lost_last <= 1'b0;
						if (!fin) begin
							bidx  <= 1'b1;
							state <= S_RD;
						end else begin
							bidx <= 1'b0;
							src_ptr[act] <= step(src_ptr[act], cfg[act][CB_MISC][7:SINC_LSB],
								is_word);
							dst_ptr[act] <= step(dst_ptr[act], cfg[act][CB_MISC][5:DINC_LSB],
								is_word);
							if (new_cnt >= eff_lim) begin
								done_p  <= 1'b1;
								done_ch <= act;
								state   <= S_IDLE;
								if (cfg[act][CB_MODE][6:TMODE_LSB] == TM_RSINGLE
									|| cfg[act][CB_MODE][6:TMODE_LSB] == TM_RBLOCK) begin
									src_ptr[act] <= {cfg[act][CB_SRCH], cfg[act][CB_SRCL]};
									dst_ptr[act] <= {cfg[act][CB_DSTH], cfg[act][CB_DSTL]};
									cnt[act]     <= '0;
									lim[act]     <= {cfg[act][CB_VARL][4:0], cfg[act][CB_LENL]};
								end else begin
									disarm_p <= 1'b1;
								end
							end else begin
								cnt[act] <= 13'(new_cnt);
								lim[act] <= 13'(eff_lim);
								if (cfg[act][CB_MODE][TMODE_LSB]) begin
									state <= S_RD;
								end else begin
									state <= S_IDLE;
								end
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			armed      <= '0;
			ready      <= '0;
			fetch_pend <= '0;
		end else begin
			armed      <= (armed | arm_set) & ~abort_mask
				& ~(disarm_p ? NCH'(1) << done_ch : '0);
			fetch_pend <= (fetch_pend | arm_set) & ~abort_mask
				& ~(fstart ? NCH'(1) << act : '0);
			ready      <= (ready | (fetch_done ? NCH'(1) << fdone_ch : '0) & armed)
				& ~abort_mask & ~arm_set & ~(disarm_p ? NCH'(1) << done_ch : '0);
		end
	end

	// Missed-trigger counts and software requests
	always_ff @(posedge CLK) begin
		if (SRST) begin
			swreq   <= '0;
			nocount <= '0;
			for (int c = 0; c < NCH; c++) begin
				pend[c] <= RST_BYTE;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				// cleared only by its transfer; set wins
				swreq[c] <= wr_req[c] || (swreq[c] && !(start_p && act == 3'(c)));
				if (fetch_done && fdone_ch == 3'(c)) begin
					nocount[c] <= 1'b0;
				end else if (wr_req[c] && !ready[c]) begin
					nocount[c] <= 1'b1;
				end
				if (wr_req[c]) begin
					pend[c] <= RST_BYTE;
				end else if (armed[c] && trig_hit[c] && (ready[c] || !nocount[c])) begin
					if (!(start_p && act == 3'(c) && !swreq[c]) && pend[c] != PEND_MAX) begin
						pend[c] <= 8'(pend[c] + 8'h01);
					end
				end else if (start_p && act == 3'(c) && !swreq[c] && pend[c] != 8'h00) begin
					pend[c] <= 8'(pend[c] - 8'h01);
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			irq_flag <= '0;
			IRQ_REQ  <= '0;
		end else begin
			irq_flag <= ((WR && ADDR == REG_IRQ) ? irq_flag & WDATA[NCH-1:0] : irq_flag)
				| (done_p ? NCH'(1) << done_ch : '0);
			IRQ_REQ  <= (done_p && cfg[done_ch][CB_MISC][MASK_BIT]) ? NCH'(1) << done_ch : '0;
		end
	end

	// Configuration base addresses
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cfg0_base <= RST_WORD;
			cfg1_base <= RST_WORD;
		end else if (WR) begin
			if (ADDR == REG_CFG0L) cfg0_base[7:0]  <= WDATA;
			if (ADDR == REG_CFG0H) cfg0_base[15:8] <= WDATA;
			if (ADDR == REG_CFG1L) cfg1_base[7:0]  <= WDATA;
			if (ADDR == REG_CFG1H) cfg1_base[15:8] <= WDATA;
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RDATA <= RST_BYTE;
		end else if (RD) begin
			unique case (ADDR)
				REG_ARM:   RDATA <= 8'(armed);
				REG_REQ:   RDATA <= 8'(swreq);
				REG_IRQ:   RDATA <= 8'(irq_flag);
				REG_CFG0L: RDATA <= cfg0_base[7:0];
				REG_CFG0H: RDATA <= cfg0_base[15:8];
				REG_CFG1L: RDATA <= cfg1_base[7:0];
				REG_CFG1H: RDATA <= cfg1_base[15:8];
				REG_READY: RDATA <= 8'(ready);
				default:   RDATA <= RST_BYTE;
			endcase
		end else begin
			RDATA <= RST_BYTE;
		end
	end
endmodule
`default_nettype wire

/* bench/fdma_chk_sva.sv */
// Port-level checker of the DMA controller.
// Assumes it is bound to fdma_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fdma_chk
	import fdma_pkg::*;
(
	input wire logic        CLK,
	input wire logic        SRST,
	input wire logic [7:0]  ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [7:0]  MEM_WDATA,
	input wire logic        MEM_RE,
	input wire logic        MEM_WE,
	input wire logic [7:0]  MEM_RDATA,
	input wire logic [4:0]  IRQ_REQ
);
	logic       armed;
	logic [3:0] run;
	logic [7:0] last;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	always_ff @(posedge CLK) begin
		if (SRST) begin
			armed <= 1'b0;
			run   <= 4'h0;
		end else begin
			if (WR && ADDR == REG_ARM && !WDATA[7] && WDATA[4:0] != 5'h00)
				armed <= 1'b1;
			run <= MEM_RE ? run + 4'h1 : 4'h0;
		end
	end
	// Last byte returned, what a write must carry
	always_ff @(posedge CLK) begin
		if ($past(MEM_RE))
			last <= MEM_RDATA;
	end
	sequence s_arm_first;
		WR && ADDR == REG_ARM && !WDATA[7] && WDATA[4:0] != 5'h00 && !armed;
	endsequence
	sequence s_fetch;
		MEM_RE [*8] ##1 !MEM_RE;
	endsequence
	// Arm is taken, fetch pending next cycle, first read the cycle after
	a_fetch_burst: assert property (s_arm_first |-> ##2 s_fetch)
		else $error("fetch is not eight reads");
	a_no_early_access: assert property (MEM_RE || MEM_WE |-> armed)
		else $error("memory access before any arm");
	a_fetch_run: assert property (run <= 4'h8)
		else $error("read run longer than one fetch");
	a_fetch_step: assert property (MEM_RE && $past(MEM_RE) |-> MEM_ADDR == $past(MEM_ADDR) + 16'h1)
		else $error("fetch address not sequential");
	a_irq_pulse: assert property (IRQ_REQ != 5'h00 |-> $onehot(IRQ_REQ) ##1 IRQ_REQ == 5'h00)
		else $error("completion request not a single pulse");
	a_irq_after_write: assert property (IRQ_REQ != 5'h00 |-> $past(MEM_WE))
		else $error("completion without a final write");
	a_wdata_copy: assert property (MEM_WE |-> MEM_WDATA == last)
		else $error("written byte differs from byte read");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside its cycle");
endmodule
bind fdma_ctrl fdma_chk i_fdma_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
	.MEM_RE(MEM_RE), .MEM_WE(MEM_WE), .MEM_RDATA(MEM_RDATA), .IRQ_REQ(IRQ_REQ));
`default_nettype wire

/* bench/fdma_mem.sv */
// Behavioural data-space memory on the far side of the DMA port.
// Assumes one-cycle read and write strobes on CLK.
`timescale 1ns/1ps
`default_nettype none
module fdma_mem (
	input  wire logic        CLK,
	input  wire logic [15:0] MEM_ADDR,
	input  wire logic [7:0]  MEM_WDATA,
	input  wire logic        MEM_RE,
	input  wire logic        MEM_WE,
	output logic      [7:0]  MEM_RDATA
);
	logic [7:0] mem [0:65535];
	logic [7:0] q;
	logic       v;
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h00;
		v = 1'b0;
		q = 8'h00;
	end
	always @(posedge CLK) begin
		v <= MEM_RE;
		if (MEM_RE)
			q <= mem[MEM_ADDR];
		if (MEM_WE)
			mem[MEM_ADDR] <= MEM_WDATA;
	end
	// Outside the answer cycle the bus shows garbage, not stale data
	assign MEM_RDATA = v ? q : ~q;
endmodule
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the DMA controller with a memory model.
// Assumes the checker is bound to the controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fdma_pkg::*;
	logic        clk, srst, wr, rd, cpu_req, mem_re, mem_we;
	logic [7:0]  addr, wdata, rdata, mem_wdata, mem_rdata, d;
	logic [31:0] trig, rs;
	logic [15:0] mem_addr;
	logic [4:0]  irq_req, irq_seen;
	logic [7:0]  sh [0:65535];
	int          n_errors, compares;
	logic [7:0]  ra   [5] = '{REG_ARM, REG_REQ, REG_IRQ, REG_READY, 8'hf0};
	logic [1:0]  sinc [5] = '{INC_P1, INC_P1, INC_NONE, INC_M1, INC_P1};
	logic [1:0]  dinc [5] = '{INC_P1, INC_M1, INC_P2, INC_NONE, INC_P1};
	logic [1:0]  pri  [5] = '{PRI_HIGH, PRI_NORM, PRI_LOW, PRI_LOW, PRI_HIGH};
	fdma_ctrl i_fdma_ctrl (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .TRIG(trig), .CPU_REQ(cpu_req), .MEM_ADDR(mem_addr),
		.MEM_WDATA(mem_wdata), .MEM_RE(mem_re), .MEM_WE(mem_we), .MEM_RDATA(mem_rdata),
		.IRQ_REQ(irq_req));
	fdma_mem i_fdma_mem (.CLK(clk), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
		.MEM_RE(mem_re), .MEM_WE(mem_we), .MEM_RDATA(mem_rdata));
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic int step(input logic [1:0] m);
		return m == INC_P1 ? 1 : m == INC_P2 ? 2 : m == INC_M1 ? -1 : 0;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pulse(input int n);
		@(posedge clk);
		trig <= 32'h1 << n;
		@(posedge clk);
		trig <= 32'h0;
	endtask
	task automatic final_report();
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// CPU contends for memory at random to exercise all priorities
	always @(posedge clk) begin
		cpu_req  <= ^xs();
		irq_seen <= srst ? 5'h00 : irq_seen | irq_req;
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		final_report();
	end
	initial begin
		rs = 32'd32;
		n_errors = 0;
		compares = 0;
		{srst, wr, rd, addr, wdata, trig} = {3'h4, 48'h0};
		for (int i = 0; i < 65536; i++)
			sh[i] = 8'h00;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		foreach (ra[i]) begin
			rreg(ra[i], d);
			chk(d, 8'h00);
		end
		// Request on an unarmed channel waits
		wreg(REG_REQ, 8'h10);
		repeat (20) @(posedge clk);
		rreg(REG_REQ, d);
		chk(d, 8'h10);
		wreg(REG_CFG0L, 8'h00);
		wreg(REG_CFG0H, 8'h01);
		wreg(REG_CFG1L, 8'h40);
		wreg(REG_CFG1H, 8'h01);
		for (int k = 0; k < 5; k++) begin
			int s, t, n, w, b;
			logic [7:0] c [8];
			s = 'h2000 + 256 * k;
			t = 'h3080 + 256 * k;
			n = k == 4 ? 4 : 1 + int'(xs() % 3);
			w = (k == 1 || k == 3) ? 2 : 1;
			b = k == 0 ? 'h100 : 'h140 + 8 * (k - 1);
			for (int i = -8; i < 8; i++) begin
				sh[s + i] = 8'(xs());
				i_fdma_mem.mem[s + i] = sh[s + i];
			end
			// Length byte: seven bits give 3, plus itself
			if (k == 4) begin
				sh[s] = 8'h83;
				i_fdma_mem.mem[s] = 8'h83;
			end
			c = '{s[15:8], s[7:0], t[15:8], t[7:0], k == 4 ? {VL_P1, 5'h00} : 8'h00,
				k == 4 ? 8'd10 : 8'(n), {w == 2, k == 4 ? TM_BLOCK : 2'(k),
				// software-started channels parked on trigger 0
				(k == 2 || k == 4) ? 5'h00 : 5'(3 + k)}, {sinc[k], dinc[k], k != 2, 1'b0, pri[k]}};
			for (int i = 0; i < 8; i++)
				i_fdma_mem.mem[b + i] = c[i];
			for (int i = 0; i < n; i++) begin
				for (int j = 0; j < w; j++)
					sh[t + j] = sh[s + j];
				s += w * step(sinc[k]);
				t += w * step(dinc[k]);
			end
			t = 'h3080 + 256 * k;
			d = 8'h00;
			wreg(REG_ARM, 8'(1 << k));
			// Trigger inside the fetch must be lost
			if (k != 2 && k != 4)
				pulse(3 + k);
			repeat (10) @(posedge clk);
			rreg(REG_READY, d);
			chk(d, 8'(1 << k));
			d = 8'h00;
			repeat (k == 4 ? 0 : k % 2 ? 1 : n) begin
				if (k == 2)
					wreg(REG_REQ, 8'h04);
				else
					pulse(3 + k);
				repeat (40) @(posedge clk);
			end
			for (int i = 0; i < 100 && d[k] !== 1'b1; i++)
				rreg(REG_IRQ, d);
			chk(d, 8'(1 << k));
			chk(8'(irq_seen), 8'(((1 << (k + 1)) - 1) & ~4));
			rreg(REG_ARM, d);
			chk(d, (k == 2 || k == 3) ? 8'(1 << k) : 8'h00);
			for (int i = -8; i < 16; i++)
				chk(i_fdma_mem.mem[t + i], sh[t + i]);
			wreg(REG_IRQ, 8'h00);
			wreg(REG_ARM, 8'h80 | 8'(1 << k));
			rreg(REG_ARM, d);
			chk(d, 8'h00);
		end
		rreg(REG_REQ, d);
		chk(d, 8'h00);
		// All five armed: ch1 first, ch0 last
		wreg(REG_ARM, 8'h1f);
		repeat (38) @(posedge clk);
		rreg(REG_READY, d);
		chk(d, 8'h1e);
		repeat (8) @(posedge clk);
		rreg(REG_READY, d);
		chk(d, 8'h1f);
		final_report();
	end
endmodule
`default_nettype wire
